// >>> hw/eac_device.sv
// What this block does
// - 2 Kbyte array addressed linearly by byte
// - Software loads address before any access
// - High address bits 10:8 in bits 2:0
// - Data register: write source, read result
// - Control: read, write, arm, irq enable bits
// - Level ready interrupt while write strobe clear
// - Arm bit self-clears four cycles later
// - Write starts only while arm still set
// - Software write sequence with arm then strobe
// - No programming while flash self-programming busy
// - Hardware clears write strobe when done
// - Write strobe halts core two cycles
// - Read strobe loads data register at once
// - Read strobe halts core four cycles
// - During write: no reads, address frozen
// - Write timed by 8448 ticks of 1 MHz
// - Keep interrupts off during write sequence
// - Poll write strobe zero before reading
`timescale 1ns/1ps
`default_nettype none
module eac_device #(
  parameter int unsigned PROG_OSC_CYCLES = eac_pkg::PROG_OSC_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  eac_if.device io
);

  logic [10:0] nvm_address;
  logic [7:0] nvm_data;
  logic ready_irq_enable;
  logic master_write_arm;
  logic write_strobe;
  logic [2:0] arm_cnt;
  logic [2:0] halt_cnt;
  logic [10:0] prog_addr;
  logic [7:0] prog_data;
  logic [5:0] osc_cnt;
  logic osc_tick;
  logic [15:0] prog_cnt;
  logic [7:0] mem [0:eac_pkg::MEM_DEPTH-1];

  logic access_ok;
  logic wr_ctrl;
  logic wr_data;
  logic wr_addr_low;
  logic wr_addr_high;
  logic read_go;
  logic write_go;
  logic prog_done;
  logic [2:0] halt_load;

  localparam logic [15:0] PROG_CNT_LAST = 16'(PROG_OSC_CYCLES - 1);
  localparam logic [5:0] OSC_LAST = 6'(eac_pkg::OSC_DIV - 1);

  // Access decode
  always_comb begin
    access_ok = !io.cpu_halt;
    wr_ctrl = io.io_wr && access_ok && (io.io_addr == eac_pkg::OFS_CONTROL);
    wr_data = io.io_wr && access_ok && (io.io_addr == eac_pkg::OFS_DATA);
    wr_addr_low = io.io_wr && access_ok && (io.io_addr == eac_pkg::OFS_ADDR_LOW);
    wr_addr_high = io.io_wr && access_ok && (io.io_addr == eac_pkg::OFS_ADDR_HIGH);
    read_go = wr_ctrl && io.io_wdata[eac_pkg::CTRL_READ] && !write_strobe;
    write_go = wr_ctrl && io.io_wdata[eac_pkg::CTRL_WRITE] && master_write_arm
      && !write_strobe && !io.flash_selfprog_busy;
    prog_done = write_strobe && osc_tick
      && (prog_cnt == PROG_CNT_LAST);
    if (write_go) begin
      halt_load = eac_pkg::WRITE_HALT_CYCLES;
    end else if (read_go) begin
      halt_load = eac_pkg::READ_HALT_CYCLES;
    end else begin
      halt_load = 3'h0;
    end
  end

  // Address registers, frozen while programming
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      nvm_address <= eac_pkg::ADDR_RESET;
    end else begin
      if (wr_addr_low && !write_strobe) begin
        nvm_address[7:0] <= io.io_wdata;
      end
      if (wr_addr_high && !write_strobe) begin
        nvm_address[10:8] <= io.io_wdata[2:0];
      end
    end
  end

  // Data register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      nvm_data <= eac_pkg::DATA_RESET;
    end else if (read_go) begin
      nvm_data <= mem[nvm_address];
    end else if (wr_data) begin
      nvm_data <= io.io_wdata;
    end
  end

  // Ready interrupt enable
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ready_irq_enable <= 1'b0;
    end else if (wr_ctrl) begin
      ready_irq_enable <= io.io_wdata[eac_pkg::CTRL_IRQ_EN];
    end
  end

  // Arm bit with its four-cycle lifetime
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      master_write_arm <= 1'b0;
      arm_cnt <= 3'h0;
    end else if (wr_ctrl) begin
      master_write_arm <= io.io_wdata[eac_pkg::CTRL_ARM];
      arm_cnt <= io.io_wdata[eac_pkg::CTRL_ARM] ? eac_pkg::ARM_CYCLES : 3'h0;
    end else if (arm_cnt != 3'h0) begin
      arm_cnt <= arm_cnt - 3'h1;
      master_write_arm <= (arm_cnt > 3'h1);
    end
  end

  // Write strobe and latched operands
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      write_strobe <= 1'b0;
      prog_addr <= eac_pkg::ADDR_RESET;
      prog_data <= eac_pkg::DATA_RESET;
    end else if (write_go) begin
      write_strobe <= 1'b1;
      prog_addr <= nvm_address;
      prog_data <= nvm_data;
    end else if (prog_done) begin
      write_strobe <= 1'b0;
    end
  end

  // Array update at end of programming
  always_ff @(posedge clk_sys) begin
    if (prog_done) begin
      mem[prog_addr] <= prog_data;
    end
  end

  // 1 MHz tick derived from the core clock
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      osc_cnt <= 6'h00;
      osc_tick <= 1'b0;
    end else begin
      osc_tick <= (osc_cnt == OSC_LAST);
      if (osc_cnt == OSC_LAST) begin
        osc_cnt <= 6'h00;
      end else begin
        osc_cnt <= osc_cnt + 6'h01;
      end
    end
  end

  // Programming time in oscillator ticks
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prog_cnt <= 16'h0000;
    end else if (write_go) begin
      prog_cnt <= 16'h0000;
    end else if (write_strobe && osc_tick) begin
      prog_cnt <= prog_cnt + 16'h0001;
    end
  end

  // Core halt after strobes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      halt_cnt <= 3'h0;
      io.cpu_halt <= 1'b0;
    end else if (halt_load != 3'h0) begin
      halt_cnt <= halt_load;
      io.cpu_halt <= 1'b1;
    end else begin
      io.cpu_halt <= (halt_cnt > 3'h1);
      if (halt_cnt != 3'h0) begin
        halt_cnt <= halt_cnt - 3'h1;
      end
    end
  end

  // Register read port
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      io.io_rdata <= 8'h00;
    end else if (io.io_rd && access_ok) begin
      unique case (io.io_addr)
        eac_pkg::OFS_CONTROL: begin
          io.io_rdata <= {4'h0, ready_irq_enable, master_write_arm, write_strobe, 1'b0};
        end
        eac_pkg::OFS_DATA: begin
          io.io_rdata <= nvm_data;
        end
        eac_pkg::OFS_ADDR_LOW: begin
          io.io_rdata <= nvm_address[7:0];
        end
        eac_pkg::OFS_ADDR_HIGH: begin
          io.io_rdata <= {5'h00, nvm_address[10:8]};
        end
        default: begin
          io.io_rdata <= 8'h00;
        end
      endcase
    end
  end

  // Level ready interrupt
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      io.ready_irq <= 1'b0;
    end else begin
      io.ready_irq <= ready_irq_enable && io.global_irq_en && !write_strobe;
    end
  end

endmodule : eac_device
`default_nettype wire

// >>> shared/eac_pkg.sv
`default_nettype none
package eac_pkg;
  // I/O register offsets
  localparam logic [5:0] OFS_CONTROL = 6'h1c;
  localparam logic [5:0] OFS_DATA = 6'h1d;
  localparam logic [5:0] OFS_ADDR_LOW = 6'h1e;
  localparam logic [5:0] OFS_ADDR_HIGH = 6'h1f;

  // Control register fields
  localparam int CTRL_READ = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_ARM = 2;
  localparam int CTRL_IRQ_EN = 3;

  // Array geometry
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 2048;
  localparam int ADDR_HIGH_W = 3;

  // Values after reset
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [10:0] ADDR_RESET = 11'h000;

  // Cycle counts on the core clock
  localparam logic [2:0] ARM_CYCLES = 3'h4;
  localparam logic [2:0] WRITE_HALT_CYCLES = 3'h2;
  localparam logic [2:0] READ_HALT_CYCLES = 3'h4;

  // Programming timer
  localparam int SYS_PERIOD_NS = 25;
  localparam int OSC_PERIOD_NS = 1000;
  localparam int OSC_DIV = OSC_PERIOD_NS / SYS_PERIOD_NS;
  localparam int OSC_CNT_W = 6;
  localparam int PROG_OSC_CYCLES = 8448;
  localparam int PROG_CNT_W = 16;
endpackage : eac_pkg
`default_nettype wire

// >>> shared/eac_if.sv
`timescale 1ns/1ps
`default_nettype none
interface eac_if;
  logic [5:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic cpu_halt;
  logic ready_irq;
  logic global_irq_en;
  logic flash_selfprog_busy;

  modport device (
    input io_addr,
    input io_wr,
    input io_rd,
    input io_wdata,
    input global_irq_en,
    input flash_selfprog_busy,
    output io_rdata,
    output cpu_halt,
    output ready_irq
  );

  modport host (
    output io_addr,
    output io_wr,
    output io_rd,
    output io_wdata,
    output global_irq_en,
    output flash_selfprog_busy,
    input io_rdata,
    input cpu_halt,
    input ready_irq
  );
endinterface : eac_if
`default_nettype wire

// >>> hw/eac_host.sv
`timescale 1ns/1ps
`default_nettype none
module eac_host (
  input wire logic clk_sys,
  input wire logic rst,
  eac_if.host io,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [10:0] req_addr,
  input wire logic [7:0] req_wdata,
  input wire logic irq_enable,
  input wire logic global_irq_enable,
  input wire logic flash_busy,
  output logic req_ready,
  output logic done,
  output logic [7:0] rdata,
  output logic irq_seen
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_POLL, ST_POLL_CHK, ST_ADDR_H, ST_ADDR_L, ST_DATA,
    ST_ARM, ST_STROBE, ST_RD_STROBE, ST_RD_DATA, ST_RD_CAP
  } eac_host_state_t;

  eac_host_state_t state;
  logic gap;
  logic op_write;
  logic [10:0] op_addr;
  logic [7:0] op_data;
  logic step;
  logic [7:0] ctrl_base;

  always_comb begin
    step = !gap && !io.cpu_halt;
    ctrl_base = 8'h00;
    ctrl_base[eac_pkg::CTRL_IRQ_EN] = irq_enable;
  end

  // Sequencer and I/O bus drive
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      gap <= 1'b0;
      op_write <= 1'b0;
      op_addr <= eac_pkg::ADDR_RESET;
      op_data <= eac_pkg::DATA_RESET;
      io.io_addr <= 6'h00;
      io.io_wr <= 1'b0;
      io.io_rd <= 1'b0;
      io.io_wdata <= 8'h00;
      req_ready <= 1'b1;
      done <= 1'b0;
      rdata <= 8'h00;
    end else begin
      io.io_wr <= 1'b0;
      io.io_rd <= 1'b0;
      done <= 1'b0;
      gap <= 1'b0;
      if (step) begin
        unique case (state)
          ST_IDLE: begin
            if (req_valid) begin
              op_write <= req_write;
              op_addr <= req_addr;
              op_data <= req_wdata;
              req_ready <= 1'b0;
              state <= ST_POLL;
            end
          end
          ST_POLL: begin
            io.io_addr <= eac_pkg::OFS_CONTROL;
            io.io_rd <= 1'b1;
            gap <= 1'b1;
            state <= ST_POLL_CHK;
          end
          ST_POLL_CHK: begin
            if (io.io_rdata[eac_pkg::CTRL_WRITE] || (op_write && flash_busy)) begin
              state <= ST_POLL;
            end else begin
              state <= ST_ADDR_H;
            end
          end
          ST_ADDR_H: begin
            io.io_addr <= eac_pkg::OFS_ADDR_HIGH;
            io.io_wdata <= {5'h00, op_addr[10:8]};
            io.io_wr <= 1'b1;
            gap <= 1'b1;
            state <= ST_ADDR_L;
          end
          ST_ADDR_L: begin
            io.io_addr <= eac_pkg::OFS_ADDR_LOW;
            io.io_wdata <= op_addr[7:0];
            io.io_wr <= 1'b1;
            gap <= 1'b1;
            state <= op_write ? ST_DATA : ST_RD_STROBE;
          end
          ST_DATA: begin
            io.io_addr <= eac_pkg::OFS_DATA;
            io.io_wdata <= op_data;
            io.io_wr <= 1'b1;
            gap <= 1'b1;
            state <= ST_ARM;
          end
          ST_ARM: begin
            io.io_addr <= eac_pkg::OFS_CONTROL;
            io.io_wdata <= ctrl_base | (8'h01 << eac_pkg::CTRL_ARM);
            io.io_wr <= 1'b1;
            gap <= 1'b1;
            state <= ST_STROBE;
          end
          ST_STROBE: begin
            io.io_addr <= eac_pkg::OFS_CONTROL;
            io.io_wdata <= ctrl_base | (8'h01 << eac_pkg::CTRL_WRITE);
            io.io_wr <= 1'b1;
            gap <= 1'b1;
            done <= 1'b1;
            req_ready <= 1'b1;
            state <= ST_IDLE;
          end
          ST_RD_STROBE: begin
            io.io_addr <= eac_pkg::OFS_CONTROL;
            io.io_wdata <= ctrl_base | (8'h01 << eac_pkg::CTRL_READ);
            io.io_wr <= 1'b1;
            gap <= 1'b1;
            state <= ST_RD_DATA;
          end
          ST_RD_DATA: begin
            io.io_addr <= eac_pkg::OFS_DATA;
            io.io_rd <= 1'b1;
            gap <= 1'b1;
            state <= ST_RD_CAP;
          end
          ST_RD_CAP: begin
            rdata <= io.io_rdata;
            done <= 1'b1;
            req_ready <= 1'b1;
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Side signals toward the device
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      io.global_irq_en <= 1'b0;
      io.flash_selfprog_busy <= 1'b0;
      irq_seen <= 1'b0;
    end else begin
      io.global_irq_en <= global_irq_enable && (state == ST_IDLE);
      io.flash_selfprog_busy <= flash_busy;
      irq_seen <= io.ready_irq;
    end
  end

endmodule : eac_host
`default_nettype wire

// >>> bench/eac_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module eac_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [5:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic cpu_halt,
  input wire logic ready_irq,
  input wire logic global_irq_en,
  input wire logic flash_selfprog_busy
);
  logic [2:0] arm_cnt;
  logic ctl_wr;
  logic ctl_rd;
  assign ctl_wr = io_wr && !cpu_halt && io_addr == eac_pkg::OFS_CONTROL;
  assign ctl_rd = io_rd && !cpu_halt && io_addr == eac_pkg::OFS_CONTROL;
  // Mirror of the arm window
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      arm_cnt <= 3'h0;
    end else if (ctl_wr) begin
      arm_cnt <= io_wdata[2] ? eac_pkg::ARM_CYCLES : 3'h0;
    end else if (arm_cnt != 3'h0) begin
      arm_cnt <= arm_cnt - 3'h1;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  chk_read_halt_four: assert property (ctl_wr && io_wdata[0] && !io_wdata[1]
    |=> cpu_halt[*4] ##1 !cpu_halt) else $error("read halt length");
  chk_write_halt_two: assert property (ctl_wr && io_wdata[1] && arm_cnt != 3'h0
    && !flash_selfprog_busy |=> cpu_halt[*2] ##1 !cpu_halt) else $error("write halt length");
  chk_halt_has_cause: assert property ($rose(cpu_halt)
    |-> $past(ctl_wr && (io_wdata[0] || io_wdata[1]))) else $error("halt without strobe");
  chk_rdata_holds: assert property (!$past(io_rd && !cpu_halt)
    |-> $stable(io_rdata)) else $error("read data moved");
  chk_ctrl_fields: assert property ($past(ctl_rd)
    |-> io_rdata[7:4] == 4'h0 && !io_rdata[0]) else $error("control field layout");
  chk_arm_window: assert property ($past(ctl_rd)
    |-> io_rdata[2] == ($past(arm_cnt) != 3'h0)) else $error("arm bit timing");
  chk_irq_gated: assert property (ready_irq |-> $past(global_irq_en))
    else $error("irq without global enable");
  chk_irq_busy_low: assert property ($past(ctl_rd) && io_rdata[1] |-> !ready_irq)
    else $error("irq during programming");
endmodule : eac_asserts
`default_nettype wire

// >>> bench/eac_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module eac_tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [10:0] req_addr = 11'h000;
  logic [7:0] req_wdata = 8'h00;
  logic irq_enable = 1'b1;
  logic global_irq_enable = 1'b1;
  logic flash_busy = 1'b0;
  logic req_ready;
  logic done;
  logic [7:0] rdata;
  logic irq_seen;
  int n_fail = 0;
  int check_count = 0;
  eac_if io_a ();
  eac_if io_b ();
  always #12.5 clk_sys = ~clk_sys;
  eac_device #(.PROG_OSC_CYCLES(4)) eac_device_i (.clk_sys(clk_sys), .rst(rst), .io(io_a));
  eac_device #(.PROG_OSC_CYCLES(4)) eac_device_b_i (.clk_sys(clk_sys), .rst(rst), .io(io_b));
  eac_host eac_host_i (.clk_sys(clk_sys), .rst(rst), .io(io_a), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .irq_enable(irq_enable), .global_irq_enable(global_irq_enable), .flash_busy(flash_busy),
    .req_ready(req_ready), .done(done), .rdata(rdata), .irq_seen(irq_seen));
  eac_asserts eac_asserts_i (.clk_sys(clk_sys), .rst(rst), .io_addr(io_a.io_addr),
    .io_wr(io_a.io_wr), .io_rd(io_a.io_rd), .io_wdata(io_a.io_wdata),
    .io_rdata(io_a.io_rdata), .cpu_halt(io_a.cpu_halt), .ready_irq(io_a.ready_irq),
    .global_irq_en(io_a.global_irq_en), .flash_selfprog_busy(io_a.flash_selfprog_busy));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Register access on the second device, one idle cycle after each
  task automatic bwr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    io_b.io_addr <= a;
    io_b.io_wdata <= d;
    io_b.io_wr <= 1'b1;
    @(posedge clk_sys);
    io_b.io_wr <= 1'b0;
    #1;
  endtask : bwr
  task automatic brd(input logic [5:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    io_b.io_addr <= a;
    io_b.io_rd <= 1'b1;
    @(posedge clk_sys);
    io_b.io_rd <= 1'b0;
    #1;
    v = io_b.io_rdata;
  endtask : brd
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] v;
    brd(a, v);
    check(v, exp);
  endtask : rd_chk
  // Counts halt cycles from the cycle after the accepted write
  task automatic halts(input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    while (io_b.cpu_halt === 1'b1 && n < 8'h10) begin
      n++;
      @(posedge clk_sys);
      #1;
    end
    check(n, exp);
  endtask : halts
  task automatic hop(input logic w, input logic [10:0] a, input logic [7:0] d);
    int i;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    // Hold the request until the host has taken it and dropped ready
    for (i = 0; i < 100 && req_ready !== 1'b0; i++) begin
      @(posedge clk_sys);
    end
    req_valid <= 1'b0;
    #1;
    for (i = 0; i < 3000 && done !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    check({7'h0, done}, 8'h01);
    if (done !== 1'b1) stop_test();
  endtask : hop
  initial begin
    logic [7:0] v;
    io_b.io_addr = 6'h00;
    io_b.io_wr = 1'b0;
    io_b.io_rd = 1'b0;
    io_b.io_wdata = 8'h00;
    io_b.global_irq_en = 1'b0;
    io_b.flash_selfprog_busy = 1'b0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    // Paired ends: top address, back-to-back writes, read back
    hop(1'b1, 11'h7ff, 8'h5a);
    repeat (3) @(posedge clk_sys);
    check({7'h0, irq_seen}, 8'h00);
    hop(1'b1, 11'h000, 8'ha5);
    hop(1'b0, 11'h7ff, 8'h00);
    check(rdata, 8'h5a);
    hop(1'b0, 11'h000, 8'h00);
    check(rdata, 8'ha5);
    repeat (3) @(posedge clk_sys);
    #1;
    check({7'h0, irq_seen}, 8'h01);
    @(posedge clk_sys);
    global_irq_enable <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    check({7'h0, irq_seen}, 8'h00);
    // Second device driven directly, including misuse
    rd_chk(eac_pkg::OFS_CONTROL, 8'h00);
    rd_chk(eac_pkg::OFS_DATA, eac_pkg::DATA_RESET);
    rd_chk(6'h00, 8'h00);
    bwr(eac_pkg::OFS_ADDR_HIGH, 8'hff);
    rd_chk(eac_pkg::OFS_ADDR_HIGH, 8'h07);
    bwr(eac_pkg::OFS_CONTROL, 8'h02);
    halts(8'h00);
    bwr(eac_pkg::OFS_CONTROL, 8'h04);
    rd_chk(eac_pkg::OFS_CONTROL, 8'h04);
    repeat (4) @(posedge clk_sys);
    rd_chk(eac_pkg::OFS_CONTROL, 8'h00);
    bwr(eac_pkg::OFS_CONTROL, 8'h02);
    halts(8'h00);
    io_b.flash_selfprog_busy <= 1'b1;
    bwr(eac_pkg::OFS_CONTROL, 8'h04);
    bwr(eac_pkg::OFS_CONTROL, 8'h02);
    halts(8'h00);
    io_b.flash_selfprog_busy <= 1'b0;
    io_b.global_irq_en <= 1'b1;
    bwr(eac_pkg::OFS_ADDR_HIGH, 8'h04);
    bwr(eac_pkg::OFS_ADDR_LOW, 8'h01);
    bwr(eac_pkg::OFS_DATA, 8'h3c);
    bwr(eac_pkg::OFS_CONTROL, 8'h0c);
    bwr(eac_pkg::OFS_CONTROL, 8'h0a);
    halts(8'h02);
    check({7'h0, io_b.ready_irq}, 8'h00);
    rd_chk(eac_pkg::OFS_CONTROL, 8'h0a);
    bwr(eac_pkg::OFS_DATA, 8'h99);
    bwr(eac_pkg::OFS_ADDR_LOW, 8'h55);
    rd_chk(eac_pkg::OFS_ADDR_LOW, 8'h01);
    bwr(eac_pkg::OFS_CONTROL, 8'h09);
    halts(8'h00);
    v = 8'h02;
    for (int i = 0; i < 400 && v[1] !== 1'b0; i++) brd(eac_pkg::OFS_CONTROL, v);
    check(v, 8'h08);
    if (v[1] !== 1'b0) stop_test();
    bwr(eac_pkg::OFS_CONTROL, 8'h09);
    halts(8'h04);
    rd_chk(eac_pkg::OFS_DATA, 8'h3c);
    check({7'h0, io_b.ready_irq}, 8'h01);
    io_b.global_irq_en <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check({7'h0, io_b.ready_irq}, 8'h00);
    stop_test();
  end
endmodule : eac_tb_top
`default_nettype wire
